//--- cs_decode_pkg.sv
// Package: constants, types and state layout of the chip-select decoder
package cs_decode_pkg;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] AREA_A_OFS = 8'h00;
   localparam logic [7:0] AREA_B_OFS = 8'h04;
   localparam logic [7:0] CTRL_A_OFS = 8'h08;
   localparam logic [7:0] CTRL_B_OFS = 8'h0C;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h14;
   localparam logic [7:0] STATE_OFS = 8'h18;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int AREA_TOP_LSB = 24;
   localparam int AREA_START_LSB = 16;
   localparam int AREA_SIZE_LSB = 0;
   localparam int CTRL_WRR_LSB = 0;
   localparam int CTRL_RDR_LSB = 4;
   localparam logic [31:0] AREA_RESET = 32'h0000_0000;
   localparam logic [2:0] RECOVERY_RESET = 3'h0;
   localparam logic [7:0] SIZE_CODE_MAX = 8'h08;
   localparam logic [2:0] RECOVERY_CODE_EIGHT = 3'h7;
   localparam logic [3:0] RECOVERY_EIGHT = 4'h8;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_MISS_BIT = 1;
   localparam int IRQ_DONE_BIT = 2;
   localparam int IRQ_W = 3;

   // ----------------------------------------------------------------
   // External window and AXI responses
   // ----------------------------------------------------------------
   localparam logic [31:0] EXT_WIN_LO = 32'h6000_0000;
   localparam logic [31:0] EXT_WIN_HI = 32'h61FF_FFFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } axil_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } ext_req_s;

   typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_RECOVER} seq_e;

   // ----------------------------------------------------------------
   // Whole state of the decoder
   // ----------------------------------------------------------------
   typedef struct packed {
      axil_rsp_s rsp;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic [1:0][7:0] area_top;
      logic [1:0][7:0] area_start;
      logic [1:0][7:0] area_size;
      logic [1:0][2:0] wr_rec;
      logic [1:0][2:0] rd_rec;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      seq_e seq;
      logic [3:0] rec_cnt;
      logic acc_ready;
      logic acc_done;
      logic hard_fault;
      logic cs_a_n;
      logic cs_b_n;
      logic irq;
   } state_s;

endpackage

//--- cs_decode.sv
// Chip-select decoder and recovery-cycle inserter with AXI4-Lite registers
`timescale 1ns/1ps
module cs_decode
   import cs_decode_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Register bus
   input wire axil_req_s axil_req_i,
   output axil_rsp_s axil_rsp_o,
   // Access requests from the internal bus
   input wire ext_req_s ext_req_i,
   input wire logic ext_end_i,
   output logic acc_ready_o,
   output logic acc_done_o,
   output logic hard_fault_o,
   // External chip selects
   output logic chip_select_a_n_o,
   output logic chip_select_b_n_o,
   // Interrupt
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Address-compare mask from a size code; prohibited codes hit nothing
   function automatic logic [7:0] size_mask(input logic [7:0] code);
      logic [7:0] m;
      m = 8'h00;
      if (code <= SIZE_CODE_MAX)
      begin
         m = ~(8'hFF >> code[3:0]);
      end
      return m;
   endfunction

   // Recovery code to cycle count, code seven meaning eight
   function automatic logic [3:0] rec_cycles(input logic [2:0] code);
      logic [3:0] n;
      n = {1'b0, code};
      if (code == RECOVERY_CODE_EIGHT)
      begin
         n = RECOVERY_EIGHT;
      end
      return n;
   endfunction

   state_s q;
   state_s d;
   logic [1:0] hit;
   logic [7:0] msk0;
   logic [7:0] msk1;
   logic in_win;
   logic do_wr;
   logic [3:0] rec_sel;
   logic [31:0] rd_word;
   logic rd_ok;
   logic wr_ok;
   logic [31:0] wmerge;
   logic [31:0] cur;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // Window check and per-channel hit, both channels in parallel
   always_comb
   begin
      in_win = (ext_req_i.addr >= EXT_WIN_LO) &&
               (ext_req_i.addr <= EXT_WIN_HI);
      msk0 = size_mask(q.area_size[0]);
      msk1 = size_mask(q.area_size[1]);
      hit[0] = (q.area_size[0] <= SIZE_CODE_MAX) &&
               ((ext_req_i.addr[23:16] & msk0) ==
                (q.area_start[0] & msk0));
      hit[1] = (q.area_size[1] <= SIZE_CODE_MAX) &&
               ((ext_req_i.addr[23:16] & msk1) ==
                (q.area_start[1] & msk1));
   end

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------

   // Middle byte of the area registers always reads zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      case (axil_req_i.araddr[7:0])
         AREA_A_OFS:
         begin
            rd_word = {q.area_top[0], q.area_start[0], 8'h00,
                       q.area_size[0]};
         end
         AREA_B_OFS:
         begin
            rd_word = {q.area_top[1], q.area_start[1], 8'h00,
                       q.area_size[1]};
         end
         CTRL_A_OFS:
         begin
            rd_word[CTRL_WRR_LSB +: 3] = q.wr_rec[0];
            rd_word[CTRL_RDR_LSB +: 3] = q.rd_rec[0];
         end
         CTRL_B_OFS:
         begin
            rd_word[CTRL_WRR_LSB +: 3] = q.wr_rec[1];
            rd_word[CTRL_RDR_LSB +: 3] = q.rd_rec[1];
         end
         IRQ_STAT_OFS:
         begin
            rd_word[IRQ_W-1:0] = q.irq_stat;
         end
         IRQ_MASK_OFS:
         begin
            rd_word[IRQ_W-1:0] = q.irq_mask;
         end
         STATE_OFS:
         begin
            rd_word = {24'h00_0000, q.rec_cnt, 2'b00, q.seq};
         end
         default:
         begin
            rd_ok = 1'b0;
         end
      endcase
   end

   // Current value at the write address, merged with the byte lanes
   always_comb
   begin
      cur = 32'h0000_0000;
      wr_ok = 1'b1;
      case (q.aw_addr)
         AREA_A_OFS: cur = {q.area_top[0], q.area_start[0], 8'h00,
                            q.area_size[0]};
         AREA_B_OFS: cur = {q.area_top[1], q.area_start[1], 8'h00,
                            q.area_size[1]};
         CTRL_A_OFS: cur = {25'h0, q.rd_rec[0], 1'b0, q.wr_rec[0]};
         CTRL_B_OFS: cur = {25'h0, q.rd_rec[1], 1'b0, q.wr_rec[1]};
         IRQ_STAT_OFS: cur = 32'h0000_0000;
         IRQ_MASK_OFS: cur = {29'h0, q.irq_mask};
         STATE_OFS: cur = 32'h0000_0000;
         default: wr_ok = 1'b0;
      endcase
      for (int i = 0; i < 4; i++)
      begin
         wmerge[i*8 +: 8] = q.w_strb[i] ? q.w_data[i*8 +: 8] :
                            cur[i*8 +: 8];
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   always_comb
   begin
      d = q;
      d.acc_done = 1'b0;
      d.hard_fault = 1'b0;
      rec_sel = 4'h0;

      // Write address and data are taken in either order
      if (axil_req_i.awvalid && q.rsp.awready)
      begin
         d.aw_have = 1'b1;
         d.aw_addr = axil_req_i.awaddr[7:0];
      end
      if (axil_req_i.wvalid && q.rsp.wready)
      begin
         d.w_have = 1'b1;
         d.w_data = axil_req_i.wdata;
         d.w_strb = axil_req_i.wstrb;
      end
      if (q.rsp.bvalid && axil_req_i.bready)
      begin
         d.rsp.bvalid = 1'b0;
      end
      do_wr = q.aw_have && q.w_have && !q.rsp.bvalid;

      // Register write; upper byte is stored as written, 0110_0000 expected
      if (do_wr)
      begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
         case (q.aw_addr)
            AREA_A_OFS, AREA_B_OFS:
            begin
               d.area_top[q.aw_addr[2]] = wmerge[AREA_TOP_LSB +: 8];
               d.area_start[q.aw_addr[2]] = wmerge[AREA_START_LSB +: 8];
               d.area_size[q.aw_addr[2]] = wmerge[AREA_SIZE_LSB +: 8];
            end
            CTRL_A_OFS, CTRL_B_OFS:
            begin
               d.wr_rec[q.aw_addr[2]] = wmerge[CTRL_WRR_LSB +: 3];
               d.rd_rec[q.aw_addr[2]] = wmerge[CTRL_RDR_LSB +: 3];
            end
            IRQ_STAT_OFS:
            begin
               d.irq_stat = q.irq_stat & ~wmerge[IRQ_W-1:0];
            end
            IRQ_MASK_OFS:
            begin
               d.irq_mask = wmerge[IRQ_W-1:0];
            end
            default:
            begin
               d.irq_mask = q.irq_mask;
            end
         endcase
      end

      // Read: one answer at a time, data registered with rvalid
      if (q.rsp.rvalid && axil_req_i.rready)
      begin
         d.rsp.rvalid = 1'b0;
      end
      if (axil_req_i.arvalid && q.rsp.arready)
      begin
         d.rsp.rvalid = 1'b1;
         d.rsp.rdata = rd_word;
         d.rsp.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end

      // Access sequencer
      case (q.seq)
         ST_IDLE:
         begin
            if (ext_req_i.valid && q.acc_ready)
            begin
               if (!in_win)
               begin
                  d.hard_fault = 1'b1;
                  d.acc_done = 1'b1;
                  d.irq_stat[IRQ_FAULT_BIT] = 1'b1;
               end
               else if (hit[0])
               begin
                  d.cs_a_n = 1'b0;
                  d.rec_cnt = ext_req_i.write ? rec_cycles(q.wr_rec[0]) :
                              rec_cycles(q.rd_rec[0]);
                  d.seq = ST_ACCESS;
               end
               else if (hit[1])
               begin
                  d.cs_b_n = 1'b0;
                  d.rec_cnt = ext_req_i.write ? rec_cycles(q.wr_rec[1]) :
                              rec_cycles(q.rd_rec[1]);
                  d.seq = ST_ACCESS;
               end
               else
               begin
                  d.acc_done = 1'b1;
                  d.irq_stat[IRQ_MISS_BIT] = 1'b1;
               end
            end
         end
         ST_ACCESS:
         begin
            if (ext_end_i)
            begin
               d.cs_a_n = 1'b1;
               d.cs_b_n = 1'b1;
               d.acc_done = 1'b1;
               d.irq_stat[IRQ_DONE_BIT] = 1'b1;
               d.seq = (q.rec_cnt == 4'h0) ? ST_IDLE : ST_RECOVER;
            end
         end
         ST_RECOVER:
         begin
            // Count runs down to zero before idling, so every code adds exactly
            // its decoded count of dummy cycles (eight for code seven) to the zero case
            rec_sel = q.rec_cnt - 4'h1;
            if (q.rec_cnt == 4'h0)
            begin
               d.seq = ST_IDLE;
            end
            else
            begin
               d.rec_cnt = rec_sel;
            end
         end
         default:
         begin
            d.seq = ST_IDLE;
         end
      endcase

      // Registered handshake outputs follow the next state
      d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
      d.rsp.wready = !d.w_have && !d.rsp.bvalid;
      d.rsp.arready = !d.rsp.rvalid;
      d.acc_ready = (d.seq == ST_IDLE) && !d.acc_done;
      d.irq = |(d.irq_stat & d.irq_mask);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------

   // Chip selects idle high; control bits constant under reset
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.area_top <= {2{AREA_RESET[31:24]}};
         q.area_start <= {2{AREA_RESET[23:16]}};
         q.area_size <= {2{AREA_RESET[7:0]}};
         q.wr_rec <= {2{RECOVERY_RESET}};
         q.rd_rec <= {2{RECOVERY_RESET}};
         q.seq <= ST_IDLE;
         q.cs_a_n <= 1'b1;
         q.cs_b_n <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign axil_rsp_o = q.rsp;
   assign acc_ready_o = q.acc_ready;
   assign acc_done_o = q.acc_done;
   assign hard_fault_o = q.hard_fault;
   assign chip_select_a_n_o = q.cs_a_n;
   assign chip_select_b_n_o = q.cs_b_n;
   assign irq_o = q.irq;

endmodule

//--- cs_decode_assertions.sv
// Checker of chip-select decode and access sequencing at the decoder ports
`timescale 1ns/1ps
module cs_decode_assertions
   import cs_decode_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Observed ports
   input wire axil_req_s axil_req_i,
   input wire axil_rsp_s axil_rsp_o,
   input wire ext_req_s ext_req_i,
   input wire logic ext_end_i,
   input wire logic acc_ready_o,
   input wire logic acc_done_o,
   input wire logic hard_fault_o,
   input wire logic chip_select_a_n_o,
   input wire logic chip_select_b_n_o,
   input wire logic irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Access taken, window test, any select active
   wire logic take = ext_req_i.valid && acc_ready_o;
   wire logic in_win = (ext_req_i.addr >= EXT_WIN_LO) &&
      (ext_req_i.addr <= EXT_WIN_HI);
   wire logic cs_on = !chip_select_a_n_o || !chip_select_b_n_o;
   // Window faults answer at once and never select
   a_fault_out: assert property (take && !in_win |=>
      hard_fault_o && acc_done_o && !cs_on) else $error("fault missing");
   a_fault_in: assert property (take && in_win |=> !hard_fault_o)
      else $error("fault inside window");
   a_fault_pulse: assert property (hard_fault_o |=> !hard_fault_o)
      else $error("fault longer than a cycle");
   // Overlap resolves to one select only
   a_one_select: assert property (!(!chip_select_a_n_o &&
      !chip_select_b_n_o)) else $error("both selects low");
   // In window: either a select or a miss completion
   a_hit_answer: assert property (take && in_win |=>
      cs_on ^ acc_done_o) else $error("bad decode answer");
   // Select holds until the far side ends the access
   a_cs_hold: assert property (cs_on && !ext_end_i |=>
      $stable(chip_select_a_n_o) && $stable(chip_select_b_n_o))
      else $error("select changed early");
   a_end_release: assert property (cs_on && ext_end_i |=>
      !cs_on && acc_done_o) else $error("select not released");
   a_busy_ready: assert property (cs_on || acc_done_o |->
      !acc_ready_o) else $error("ready while busy");
   // Main scenarios
   c_fault: cover property (take && !in_win);
   c_sel_a: cover property (!chip_select_a_n_o);
   c_sel_b: cover property (!chip_select_b_n_o);
endmodule
bind cs_decode cs_decode_assertions u_cs_decode_assertions (
   .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .axil_req_i(axil_req_i),
   .axil_rsp_o(axil_rsp_o), .ext_req_i(ext_req_i), .ext_end_i(ext_end_i),
   .acc_ready_o(acc_ready_o), .acc_done_o(acc_done_o),
   .hard_fault_o(hard_fault_o), .chip_select_a_n_o(chip_select_a_n_o),
   .chip_select_b_n_o(chip_select_b_n_o), .irq_o(irq_o));

//--- ext_dev_model.sv
// External device that ends each selected access after a fixed wait
`timescale 1ns/1ps
module ext_dev_model #(
   parameter logic [3:0] WAIT = 4'h2
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Selects and end strobe
   input wire logic chip_select_a_n_i,
   input wire logic chip_select_b_n_i,
   output logic ext_end_o
);
   logic [3:0] cnt_q;
   // Guard on ext_end_o avoids a second end while select rises
   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 4'h0;
         ext_end_o <= 1'b0;
      end
      else
      begin
         ext_end_o <= 1'b0;
         if ((!chip_select_a_n_i || !chip_select_b_n_i) && !ext_end_o)
         begin
            ext_end_o <= (cnt_q == WAIT);
            cnt_q <= (cnt_q == WAIT) ? 4'h0 : cnt_q + 4'h1;
         end
      end
   end
endmodule

//--- external_bus_cs_decode_recovery_tb.sv
// Testbench of the chip-select decoder over AXI4-Lite and the access port
`timescale 1ns/1ps
module external_bus_cs_decode_recovery_tb
   import cs_decode_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   axil_req_s axi_req = '0;
   axil_rsp_s axi_rsp;
   ext_req_s ext_req = '0;
   logic ext_end, acc_ready, acc_done, fault, cs_a_n, cs_b_n, irq;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [1:0] rr;
   logic [3:0] obs;
   int gap;
   cs_decode u_cs_decode (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .axil_req_i(axi_req), .axil_rsp_o(axi_rsp), .ext_req_i(ext_req),
      .ext_end_i(ext_end), .acc_ready_o(acc_ready), .acc_done_o(acc_done),
      .hard_fault_o(fault), .chip_select_a_n_o(cs_a_n),
      .chip_select_b_n_o(cs_b_n), .irq_o(irq));
   ext_dev_model u_ext_dev_model (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .chip_select_a_n_i(cs_a_n), .chip_select_b_n_i(cs_b_n),
      .ext_end_o(ext_end));
   // Clock and hang guard
   initial forever #5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bus tasks sample at the falling edge, so decisions never race
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e);
      logic aw, w, b;
      logic [1:0] r;
      axi_req.awaddr <= {24'h0, a};
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hF;
      {axi_req.awvalid, axi_req.wvalid, axi_req.bready} <= 3'h7;
      do
      begin
         @(negedge sys_clk_i);
         aw = axi_req.awvalid && axi_rsp.awready;
         w = axi_req.wvalid && axi_rsp.wready;
         b = axi_rsp.bvalid;
         r = axi_rsp.bresp;
         @(posedge sys_clk_i);
         if (aw) axi_req.awvalid <= 1'b0;
         if (w) axi_req.wvalid <= 1'b0;
      end while (!b);
      axi_req.bready <= 1'b0;
      chk("bresp", {30'h0, e}, {30'h0, r});
      @(posedge sys_clk_i);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      logic v;
      logic t;
      axi_req.araddr <= {24'h0, a};
      {axi_req.arvalid, axi_req.rready} <= 2'h3;
      do
      begin
         @(negedge sys_clk_i);
         t = axi_req.arvalid && axi_rsp.arready;
         v = axi_rsp.rvalid;
         d = axi_rsp.rdata;
         rr = axi_rsp.rresp;
         @(posedge sys_clk_i);
         if (t) axi_req.arvalid <= 1'b0;
      end while (!v);
      axi_req.rready <= 1'b0;
      @(posedge sys_clk_i);
   endtask
   // One access: first-cycle answer and done-to-ready gap
   task automatic acc(input logic [31:0] a, input logic w);
      while (!acc_ready) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
      ext_req <= '{valid: 1'b1, write: w, addr: a};
      @(posedge sys_clk_i);
      ext_req.valid <= 1'b0;
      @(negedge sys_clk_i);
      obs = {cs_a_n, cs_b_n, fault, acc_done};
      while (!acc_done) @(negedge sys_clk_i);
      gap = 0;
      do
      begin
         @(negedge sys_clk_i);
         gap++;
      end while (!acc_ready);
      @(posedge sys_clk_i);
   endtask
   function automatic int cycles(input int c);
      return (c == 7) ? 8 : c;
   endfunction
   task automatic finish_test();
      $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rd_reg(AREA_A_OFS, rd); chk("area reset", AREA_RESET, rd);
      wr(AREA_A_OFS, 32'h6000_FF08, RESP_OKAY);
      rd_reg(AREA_A_OFS, rd); chk("area rb", 32'h6000_0008, rd);
      chk("rresp ok", RESP_OKAY, rr);
      wr(8'h40, 32'h1, RESP_SLVERR);
      rd_reg(8'h40, rd);
      chk("rd unmapped", 32'h0, rd);
      chk("rresp err", RESP_SLVERR, rr);
      // Size codes: edge of area hits, one past it misses for codes 1 to 8
      wr(AREA_B_OFS, 32'h6000_0009, RESP_OKAY);
      for (int c = 0; c < 9; c++)
      begin
         wr(AREA_A_OFS, 32'h6000_0000 | c, RESP_OKAY);
         acc(EXT_WIN_LO + (32'h1 << (24 - c)) - 32'h1_0000, 1'b0);
         chk("size hit", 4'b0100, obs);
         acc(EXT_WIN_LO + (32'h1 << (24 - c)), 1'b0);
         chk("size edge", (c == 0) ? 4'b0100 : 4'b1101, obs);
      end
      // Overlap, second channel, window limits
      wr(AREA_A_OFS, 32'h6010_0008, RESP_OKAY);
      wr(AREA_B_OFS, 32'h6010_0000, RESP_OKAY);
      acc(32'h6010_1234, 1'b1); chk("overlap", 4'b0100, obs);
      acc(32'h6011_0000, 1'b0); chk("chan b", 4'b1000, obs);
      acc(EXT_WIN_HI - 32'h3, 1'b0); chk("top", 4'b1000, obs);
      acc(EXT_WIN_LO - 32'h4, 1'b0); chk("below", 4'b1111, obs);
      wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
      acc(EXT_WIN_HI + 32'h1, 1'b1); chk("above", 4'b1111, obs);
      // Fault interrupt: masked, unmasked, cleared
      chk("irq masked", 1'b0, irq);
      rd_reg(IRQ_STAT_OFS, rd); chk("stat", 32'h1, rd & 32'h1);
      wr(IRQ_MASK_OFS, 32'h1, RESP_OKAY);
      @(negedge sys_clk_i); chk("irq on", 1'b1, irq);
      wr(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
      @(negedge sys_clk_i); chk("irq off", 1'b0, irq);
      // Recovery: every code, read and write set apart
      for (int c = 0; c < 8; c++)
      begin
         wr(CTRL_A_OFS, ((7 - c) << CTRL_RDR_LSB) | c, RESP_OKAY);
         acc(32'h6010_0000, 1'b1);
         chk("wr gap", cycles(c) + 1, gap);
         acc(32'h6010_0000, 1'b0);
         chk("rd gap", cycles(7 - c) + 1, gap);
      end
      // Channel b keeps its own recovery counts
      wr(CTRL_B_OFS, 32'h25, RESP_OKAY);
      acc(32'h6011_0000, 1'b1);
      chk("b wr gap", 32'h6, gap);
      acc(32'h6011_0000, 1'b0);
      chk("b rd gap", 32'h3, gap);
      // Reset in mid-access: select released at once, registers cleared
      ext_req <= '{valid: 1'b1, write: 1'b0, addr: 32'h6010_0000};
      @(posedge sys_clk_i);
      ext_req.valid <= 1'b0;
      @(negedge sys_clk_i);
      chk("cs before reset", 1'b0, cs_a_n);
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      @(negedge sys_clk_i);
      chk("reset outputs", 4'b1100, {cs_a_n, cs_b_n, acc_ready,
         axi_rsp.arready});
      repeat (2) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rd_reg(CTRL_A_OFS, rd);
      chk("ctrl reset", 32'h0, rd);
      rd_reg(STATE_OFS, rd);
      chk("state idle", 32'h0, rd);
      finish_test();
   end
endmodule
